// ### bench/adcp_host.sv
/* Host processor model: host clock, select framing and byte cycles.
   Assumes clk_i is the system clock of the device. */
`timescale 1ns/1ps
`default_nettype none
module adcp_host (
   // System side
   input  wire logic       clk_i,
   input  wire logic [7:0] data_o,
   input  wire logic       data_oe_n_o,
   // Host bus
   output logic            host_clk_o,
   output logic            cs_n_o,
   output logic            rw_o,
   output logic            rs_o,
   output logic [7:0]      data_bus_o
);
   logic [7:0] wd = 8'h00;
   logic [7:0] last = 8'h00;
   logic [7:0] bus;
   // Released bus shows the inverse of the last value, never a stale copy
   always @(posedge clk_i) if (!data_oe_n_o) last <= data_o;
   assign bus = data_oe_n_o ? ~last : data_o;
   assign data_bus_o = rw_o ? bus : wd;
   initial begin
      host_clk_o = 1'b0;
      cs_n_o = 1'b1;
      rw_o = 1'b1;
      rs_o = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cyc
   task automatic frame(input logic c, input logic r, input logic s);
      cs_n_o = c;
      rw_o = r;
      rs_o = s;
   endtask : frame
   task automatic byte_cyc(input logic [7:0] d, output logic [7:0] rd,
                           output logic oh, output logic fl);
      wd = d;
      host_clk_o = 1'b1;
      cyc(4);
      rd = bus;
      oh = data_oe_n_o;
      host_clk_o = 1'b0;
      cyc(3);
      fl = data_oe_n_o;
   endtask : byte_cyc
   // select taken while the host clock is already high
   task automatic late_sel(input logic [7:0] d);
      wd = d;
      host_clk_o = 1'b1;
      cyc(2);
      frame(1'b0, 1'b0, 1'b1);
      cyc(2);
      host_clk_o = 1'b0;
      cyc(3);
   endtask : late_sel
   // select high a full cycle ends access
   task automatic stop;
      logic [7:0] d;
      logic       a;
      logic       b;
      frame(1'b1, rw_o, rs_o);
      byte_cyc(8'h00, d, a, b);
      byte_cyc(8'h00, d, a, b);
   endtask : stop
endmodule : adcp_host
`default_nettype wire

// ### bench/adcp_top_tb.sv
/* Self-checking bench of the converter host port.
   Assumes the fast variant and an ideal comparator on the analog side. */
`timescale 1ns/1ps
`default_nettype none
`include "adcp_defs.svh"
module adcp_top_tb;
   logic       clk_i = 1'b0;
   logic       resetn_i;
   logic       rst_pin_n;
   logic       hclk, cs_n, rw, rs, oe_n, st, smp, comp;
   logic [7:0] din, dout, trial;
   logic [7:0] ana;
   logic [5:0] dig;
   logic [3:0] chan;
   int         err_total = 0;
   int         num_checks = 0;
   always #12.5 clk_i = ~clk_i;
   assign comp = (ana >= trial);
   adcp_top #(.FAST_VARIANT(1'b1)) i_adcp_top (.clk_i(clk_i), .resetn_i(resetn_i),
      .reset_pin_n_i(rst_pin_n), .host_clk_i(hclk), .cs_n_i(cs_n), .rw_i(rw),
      .register_select_in_i(rs), .data_i(din), .data_o(dout), .data_oe_n_o(oe_n),
      .dig_pins_i(dig), .comp_i(comp), .channel_select_bits_o(chan),
      .selftest_o(st), .sample_o(smp), .trial_o(trial));
   adcp_host i_adcp_host (.clk_i(clk_i), .data_o(dout), .data_oe_n_o(oe_n),
      .host_clk_o(hclk), .cs_n_o(cs_n), .rw_o(rw), .rs_o(rs), .data_bus_o(din));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   task automatic rd(input logic s, input int n, output logic [7:0] m, output logic [7:0] l);
      logic [7:0] b;
      logic       oh;
      logic       fl;
      i_adcp_host.frame(1'b0, 1'b1, s);
      for (int k = 0; k < n; k++) begin
         i_adcp_host.byte_cyc(8'h00, b, oh, fl);
         chk({7'h00, oh}, 8'h00); // driven while high
         chk({7'h00, fl}, 8'h01); // floats while low
         if (k == 0) m = b;
         else if (k == 1) l = b;
         else chk(b, l); // pointer stays low
      end
      i_adcp_host.stop();
   endtask : rd
   task automatic wr16(input logic [7:0] hi, input logic [7:0] lo);
      logic [7:0] b;
      logic       oh;
      logic       fl;
      i_adcp_host.frame(1'b0, 1'b0, 1'b1);
      i_adcp_host.byte_cyc(hi, b, oh, fl);
      i_adcp_host.byte_cyc(lo, b, oh, fl);
      i_adcp_host.stop();
   endtask : wr16
   task automatic t_reset;
      chk({7'h00, oe_n}, 8'h01); // bus floats
      chk({7'h00, smp}, 8'h00); // converter idle
   endtask : t_reset
   task automatic t_conv(input logic [3:0] ch, input logic [7:0] v);
      logic [7:0] m;
      logic [7:0] l;
      ana = v;
      wr16(8'h80, {4'h0, ch});
      chk({4'h0, chan}, {4'h0, ch}); // channel taken
      chk({7'h00, st}, {7'h00, ch == `ADCP_CHAN_SELFTEST}); // self-test
      chk({7'h00, smp}, 8'h01); // acquire begun
      i_adcp_host.cyc(150);
      rd(1'b0, 1, m, l);
      chk(m, 8'h00); // done clear
      i_adcp_host.cyc(215);
      rd(1'b0, 2, m, l);
      chk(m, 8'h80); // done only
      chk(l, v); // result in time
   endtask : t_conv
   task automatic t_abort;
      logic [7:0] m;
      logic [7:0] l;
      ana = 8'h11;
      wr16(8'h80, 8'h03);
      i_adcp_host.cyc(100);
      ana = 8'h5a;
      wr16(8'h80, 8'h04);
      i_adcp_host.cyc(280);
      rd(1'b0, 1, m, l);
      chk(m, 8'h00); // first one aborted
      i_adcp_host.cyc(90);
      rd(1'b0, 2, m, l);
      chk(l, 8'h5a); // new result
   endtask : t_abort
   task automatic t_lone;
      logic [7:0] b;
      logic       oh;
      logic       fl;
      i_adcp_host.frame(1'b0, 1'b0, 1'b1);
      i_adcp_host.byte_cyc(8'h80, b, oh, fl);
      i_adcp_host.stop();
      chk({7'h00, smp}, 8'h00); // lone byte no start
      i_adcp_host.frame(1'b0, 1'b0, 1'b0);
      i_adcp_host.byte_cyc(8'h80, b, oh, fl);
      i_adcp_host.byte_cyc(8'h07, b, oh, fl);
      i_adcp_host.stop();
      chk({4'h0, chan}, 8'h04); // write needs register select
      chk({7'h00, smp}, 8'h00); // no start either
      i_adcp_host.late_sel(8'h80);
      i_adcp_host.byte_cyc(8'h09, b, oh, fl);
      i_adcp_host.stop();
      chk({4'h0, chan}, 8'h04); // early fall moves nothing
      chk({7'h00, smp}, 8'h00); // no start
   endtask : t_lone
   task automatic t_cs_high;
      logic [7:0] b;
      logic       oh;
      logic       fl;
      i_adcp_host.frame(1'b1, 1'b0, 1'b1);
      i_adcp_host.byte_cyc(8'h80, b, oh, fl);
      i_adcp_host.byte_cyc(8'h07, b, oh, fl);
      chk({4'h0, chan}, 8'h04); // write ignored
      chk({7'h00, smp}, 8'h00); // no start
      i_adcp_host.frame(1'b1, 1'b1, 1'b0);
      i_adcp_host.byte_cyc(8'h00, b, oh, fl);
      chk({7'h00, oh}, 8'h01); // nothing driven
   endtask : t_cs_high
   task automatic t_dig;
      logic [7:0] m;
      logic [7:0] l;
      dig = 6'h2d;
      rd(1'b1, 3, m, l);
      chk(m, 8'h2d); // pin levels
      chk(l, 8'h04); // channel shown
      dig = 6'h12;
      rd(1'b1, 1, m, l);
      chk(m, 8'h12); // high byte again
   endtask : t_dig
   task automatic t_pinrst;
      logic [7:0] m;
      logic [7:0] l;
      ana = 8'h3c;
      wr16(8'h80, 8'h06);
      i_adcp_host.cyc(100);
      rst_pin_n = 1'b0;
      i_adcp_host.stop();
      i_adcp_host.stop();
      chk(trial, 8'h00); // converter idled
      chk({7'h00, oe_n}, 8'h01); // bus floats
      rst_pin_n = 1'b1;
      i_adcp_host.cyc(400);
      rd(1'b0, 2, m, l);
      chk(m, 8'h00); // done flag still clear
      chk(l, 8'h5a); // result kept
   endtask : t_pinrst
   initial begin
      resetn_i = 1'b0;
      rst_pin_n = 1'b1;
      ana = 8'h00;
      dig = 6'h00;
      repeat (6) @(posedge clk_i);
      #1;
      resetn_i = 1'b1;
      i_adcp_host.cyc(2);
      t_reset();
      t_conv(4'h5, 8'h9b);
      t_conv(`ADCP_CHAN_LAST_EXT, 8'h00);
      t_conv(`ADCP_CHAN_SELFTEST, 8'hff);
      t_abort();
      t_lone();
      t_cs_high();
      t_dig();
      t_pinrst();
      end_sim();
   end
   // Tests need about 66 us; seven and a half times that means a hang
   initial begin
      #500000;
      err_total++;
      end_sim();
   end
endmodule : adcp_top_tb
`default_nettype wire

// ### hw/adcp_defs.svh
/*
 Constants of the converter host port: field positions, channel codes,
 reset values and conversion timing.
 Assumes it is included by its bare name from the design files.
*/
`ifndef ADCP_DEFS_SVH
`define ADCP_DEFS_SVH

// Command register fields
`define ADCP_CMD_SC_BIT      7
`define ADCP_CHAN_W          4
// Conversion register fields
`define ADCP_DONE_BIT        7
// Digital input register fields
`define ADCP_DIG_W           6
// Channel codes: 0..10 external, 11 self-test on the positive reference
`define ADCP_CHAN_LAST_EXT   4'ha
`define ADCP_CHAN_SELFTEST   4'hb
`define ADCP_CHAN_RST        4'h0
`define ADCP_RESULT_RST      8'h00
// Conversion timing
`define ADCP_CLK_MHZ         40
`define ADCP_CONV_NS_FAST    10000
`define ADCP_CONV_NS_SLOW    20000
`define ADCP_SAR_BITS        8
`define ADCP_SAR_STEPS       9

`endif

// ### hw/adcp_pkg.sv
/*
 Types of the converter host port: sequencer states and the state records
 of the sequencer and of the host port.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package adcp_pkg;

   typedef enum logic [1:0] {
      SAR_IDLE = 2'b00,
      SAR_ACQ  = 2'b01,
      SAR_CONV = 2'b10
   } adcp_sar_state_t;

   typedef struct packed {
      adcp_sar_state_t state;
      logic [9:0]      cnt;
      logic [2:0]      bit_idx;
      logic [7:0]      trial;
      logic [7:0]      result;
      logic            done;
   } adcp_sar_st_t;

   typedef struct packed {
      logic       clk_prev;
      logic       armed;
      logic       cs_hi_seen;
      logic       ptr_lsb;
      logic [7:0] cmd_msb;
      logic [3:0] chan;
      logic       selftest;
      logic       sc;
      logic       done;
      logic [7:0] dout;
      logic       doe_n;
   } adcp_top_st_t;

endpackage : adcp_pkg

// ### hw/adcp_sar.sv
/*
 Fixed-length successive-approximation sequencer: one acquire step, then
 one bit decision per step, stepped by an enable from a divider.
 Assumes an external comparator answers comp_i for the code on trial_o
 within one step.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcp_defs.svh"

module adcp_sar #(
   parameter int STEP_CYC = 44
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   // Control
   input  wire logic       idle_i,
   input  wire logic       start_i,
   input  wire logic       comp_i,
   // Status and result
   output logic            busy_o,
   output logic            done_o,
   output logic            sample_o,
   output logic [7:0]      result_o,
   output logic [7:0]      trial_o
);

   localparam int CONV_LIM = STEP_CYC * `ADCP_SAR_STEPS + 2;
   localparam logic [9:0] STEP_LAST = 10'(STEP_CYC - 1);

   adcp_pkg::adcp_sar_st_t r;
   adcp_pkg::adcp_sar_st_t n;
   logic                   step;

   always_comb begin
      n      = r;
      step   = (r.cnt == STEP_LAST);
      n.done = 1'b0;
      n.cnt  = step ? 10'h000 : 10'(r.cnt + 10'h001);
      case (r.state)
         adcp_pkg::SAR_ACQ: begin
            if (step) begin
               n.state   = adcp_pkg::SAR_CONV;
               n.bit_idx = 3'h7;
               n.trial   = 8'h80;
            end
         end
         adcp_pkg::SAR_CONV: begin
            if (step) begin
               if (!comp_i) begin
                  n.trial[r.bit_idx] = 1'b0;
               end
               if (r.bit_idx == 3'h0) begin
                  n.result = n.trial;
                  n.done   = 1'b1;
                  n.state  = adcp_pkg::SAR_IDLE;
               end else begin
                  n.bit_idx          = 3'(r.bit_idx - 3'h1);
                  n.trial[n.bit_idx] = 1'b1;
               end
            end
         end
         default: begin
            n.cnt = 10'h000;
         end
      endcase
      if (start_i) begin
         n.state = adcp_pkg::SAR_ACQ;
         n.cnt   = 10'h000;
         n.trial = 8'h00;
         n.done  = 1'b0;
      end
      if (idle_i) begin
         // A last step landing on the idle cycle must not overwrite the kept result
         n.result = r.result;
         n.state = adcp_pkg::SAR_IDLE;
         n.cnt   = 10'h000;
         n.trial = 8'h00;
         n.done  = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r <= '{state: adcp_pkg::SAR_IDLE, cnt: 10'h000, bit_idx: 3'h0,
                trial: 8'h00, result: `ADCP_RESULT_RST, done: 1'b0};
      end else begin
         r <= n;
      end
   end

   assign busy_o   = (r.state != adcp_pkg::SAR_IDLE);
   assign done_o   = r.done;
   // Acquire is the only state code with bit 0 set, so this stays a plain flop
   assign sample_o = r.state[0];
   assign result_o = r.result;
   assign trial_o  = r.trial;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   conv_time_bound_a: assert property (
      (start_i && !idle_i) |-> ##[1:CONV_LIM] (done_o || start_i || idle_i))
      else $error("conversion did not finish in time");
   result_hold_a: assert property (
      !done_o |-> $stable(result_o))
      else $error("result changed without completion");
   idle_keeps_a: assert property (
      idle_i |=> !busy_o && $stable(result_o))
      else $error("idle did not stop converter");

endmodule : adcp_sar

`default_nettype wire

// ### hw/adcp_top.sv
/*
 Host port of an 8-bit converter peripheral: byte-wide three-state bus,
 command, conversion and digital input registers, byte pointer, start,
 abort and done flag, and the conversion sequencer.
 Assumes the host bus pins and host clock are synchronous to clk_i and
 the pad logic resolves data from data_o and data_oe_n_o.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcp_defs.svh"

module adcp_top #(
   parameter bit FAST_VARIANT = 1'b1
) (
   // Clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   resetn_i,
   // Device reset pin, active low
   input  wire logic                   reset_pin_n_i,
   // Host bus
   input  wire logic                   host_clk_i,
   input  wire logic                   cs_n_i,
   input  wire logic                   rw_i,
   input  wire logic                   register_select_in_i,
   input  wire logic [7:0]             data_i,
   output logic      [7:0]             data_o,
   output logic                        data_oe_n_o,
   // Dual-purpose digital inputs
   input  wire logic [`ADCP_DIG_W-1:0] dig_pins_i,
   // Analog front end
   input  wire logic                   comp_i,
   output logic [`ADCP_CHAN_W-1:0]     channel_select_bits_o,
   output logic                        selftest_o,
   output logic                        sample_o,
   output logic [7:0]                  trial_o
);

   localparam int CONV_NS  = FAST_VARIANT ? `ADCP_CONV_NS_FAST : `ADCP_CONV_NS_SLOW;
   localparam int CONV_CYC = CONV_NS * `ADCP_CLK_MHZ / 1000;
   // Longest time: round the step length down so all steps fit
   localparam int STEP_CYC = (CONV_CYC / `ADCP_SAR_STEPS) < 1 ? 1 :
                             (CONV_CYC / `ADCP_SAR_STEPS);

   adcp_pkg::adcp_top_st_t r;
   adcp_pkg::adcp_top_st_t n;
   logic                   rise;
   logic                   fall;
   logic                   clr_done;
   logic [7:0]             conv_msb;
   logic [7:0]             dig_msb;
   logic [7:0]             dig_lsb;
   logic                   sar_busy;
   logic                   sar_done;
   logic [7:0]             sar_result;

   always_comb begin
      n        = r;
      rise     = host_clk_i && !r.clk_prev;
      fall     = !host_clk_i && r.clk_prev;
      clr_done = 1'b0;
      // only done flag in high byte
      conv_msb = 8'h00;
      conv_msb[`ADCP_DONE_BIT] = r.done;
      dig_msb  = 8'h00;
      dig_msb[`ADCP_DIG_W-1:0] = dig_pins_i;
      dig_lsb  = 8'h00;
      dig_lsb[`ADCP_CHAN_W-1:0] = r.chan;
      n.clk_prev = host_clk_i;
      // Start request lasts one cycle so a command starts exactly one conversion
      n.sc = 1'b0;
      if (!reset_pin_n_i) begin
         n.sc         = 1'b0;
         n.doe_n      = 1'b1;
         n.armed      = 1'b0;
         n.ptr_lsb    = 1'b0;
         n.cs_hi_seen = 1'b0;
      end else if (cs_n_i) begin
         n.doe_n = 1'b1;
         n.armed = 1'b0;
         if (rise) begin
            if (r.cs_hi_seen) begin
               n.ptr_lsb = 1'b0;
            end
            n.cs_hi_seen = 1'b1;
         end
      end else begin
         n.cs_hi_seen = 1'b0;
         if (rise) begin
            n.armed = 1'b1;
            if (rw_i) begin
               case ({register_select_in_i, r.ptr_lsb})
                  2'b00:   n.dout = conv_msb;
                  2'b01:   n.dout = sar_result;
                  2'b10:   n.dout = dig_msb;
                  default: n.dout = dig_lsb;
               endcase
               n.doe_n = 1'b0;
            end
         end
         if (fall && r.armed) begin
            n.doe_n = 1'b1;
            n.ptr_lsb = 1'b1;
            if (!rw_i && register_select_in_i) begin
               if (!r.ptr_lsb) begin
                  n.cmd_msb = data_i;
               end else begin
                  n.sc       = r.cmd_msb[`ADCP_CMD_SC_BIT];
                  n.chan     = data_i[`ADCP_CHAN_W-1:0];
                  n.selftest = (data_i[`ADCP_CHAN_W-1:0] == `ADCP_CHAN_SELFTEST);
                  clr_done   = 1'b1;
               end
            end
         end
      end
      // completion sets, write clears; set wins
      if (sar_done) begin
         n.done = 1'b1;
      end else if (clr_done) begin
         n.done = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r <= '{clk_prev: 1'b0, armed: 1'b0, cs_hi_seen: 1'b0, ptr_lsb: 1'b0,
                cmd_msb: 8'h00, chan: `ADCP_CHAN_RST, selftest: 1'b0, sc: 1'b0,
                done: 1'b0, dout: 8'h00, doe_n: 1'b1};
      end else begin
         r <= n;
      end
   end

   // sequencer stepped from system clock divider
   adcp_sar #(
      .STEP_CYC (STEP_CYC)
   ) u_sar (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .idle_i   (!reset_pin_n_i),
      .start_i  (r.sc),
      .comp_i   (comp_i),
      .busy_o   (sar_busy),
      .done_o   (sar_done),
      .sample_o (sample_o),
      .result_o (sar_result),
      .trial_o  (trial_o)
   );

   assign data_o                = r.dout;
   assign data_oe_n_o           = r.doe_n;
   assign channel_select_bits_o = r.chan;
   assign selftest_o            = r.selftest;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   deselect_floats_a: assert property (
      cs_n_i |=> data_oe_n_o)
      else $error("bus driven while deselected");
   clock_low_float_a: assert property (
      (!host_clk_i && $past(host_clk_i) && r.armed) |=> data_oe_n_o)
      else $error("bus driven with host clock low");
   reset_floats_a: assert property (
      !reset_pin_n_i |=> data_oe_n_o && !r.sc && !r.ptr_lsb)
      else $error("reset left bus or start bit active");
   conv_msb_read_a: assert property (
      (reset_pin_n_i && !cs_n_i && rw_i && !register_select_in_i && rise && !r.ptr_lsb)
      |=> (data_o == {$past(r.done), 7'h00}) && !data_oe_n_o)
      else $error("conversion high byte wrong");
   cmd_capture_a: assert property (
      (reset_pin_n_i && !cs_n_i && !rw_i && register_select_in_i && fall && r.armed
       && !r.ptr_lsb) |=> (r.cmd_msb == $past(data_i)) && r.ptr_lsb)
      else $error("command high byte not captured");
   no_arm_no_xfer_a: assert property (
      (fall && !r.armed) |=> $stable(r.cmd_msb) && $stable(r.ptr_lsb) && !r.sc)
      else $error("transfer before host clock rose");
   pointer_return_a: assert property (
      (reset_pin_n_i && cs_n_i && rise && r.cs_hi_seen) |=> !r.ptr_lsb)
      else $error("pointer did not return to high byte");
   start_runs_a: assert property (
      (r.sc && reset_pin_n_i) |=> sar_busy && !r.done ##1 !r.done)
      else $error("start did not begin conversion");
   done_clear_a: assert property (
      (sar_busy && !sar_done) |=> !r.done || $past(r.done))
      else $error("done set during conversion");

endmodule : adcp_top

`default_nettype wire
